// ==== hw/uvtm_fault_resp.sv ====
`timescale 1ns/100ps
module uvtm_fault_resp
	import uvtm_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Command port
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_wdata,
	output logic [7:0] cmd_rdata,
	// Clearing commands
	input wire logic clear_faults_cmd,
	input wire logic restore_user_all_cmd,
	input wire logic vendor_soft_reset_cmd,
	// On control
	input wire logic run_pin,
	input wire logic operation_on,
	// Sequencer state
	input wire logic ton_delay_done,
	input wire logic ton_rise_done,
	input wire logic seq_ramping,
	input wire logic ton_limit_reached,
	// Fault inputs
	input wire logic uv_below,
	input wire logic ton_max_fault,
	input wire logic [CNT_W-1:0] retry_interval_setting,
	// Alert masks
	input wire logic uv_alert_mask,
	input wire logic ton_alert_mask,
	input wire logic cml_alert_mask,
	// Output control and status
	output logic output_enable,
	output logic status_none_of_above,
	output logic status_word_vout,
	output logic status_vout_uv,
	output logic status_vout_ton_max,
	output logic cml_fault,
	// Alert, open drain
	output logic alert_o,
	output logic alert_oe
);
	typedef struct packed {
		logic run_s1;
		logic run_s2;
		logic uv_s1;
		logic uv_s2;
		logic on_prev;
		uvtm_state_t state;
		logic src_ton;
		logic armed;
		logic [7:0] uv_resp;
		logic [7:0] ton_resp;
		logic [7:0] rdata;
		logic out_en;
		logic st_noa;
		logic st_vout;
		logic st_uv;
		logic st_ton;
		logic cml;
		logic alert;
	} uvtm_mstate_t;

	localparam uvtm_mstate_t RST_VAL = '{state: ST_OFF, uv_resp: UV_RESP_RST, ton_resp: TON_RESP_RST,
		rdata: RD_NONE, default: 1'b0};

	uvtm_mstate_t r_reg, r_next;
	uvtm_tmr_if tif ();

	uvtm_timer u_timer (
		.clock(clock),
		.nrst(nrst),
		.t(tif.tmr)
	);

	logic on_now, turn_on, clr, active, arm_ok, uv_evt, ton_evt, cml_set, present;
	logic [7:0] cur;

	always_comb begin
		r_next = r_reg;
		tif.load = 1'b0;
		tif.value = CNT_ZERO;
		cml_set = 1'b0;
		r_next.run_s1 = run_pin;
		r_next.run_s2 = r_reg.run_s1;
		r_next.uv_s1 = uv_below;
		r_next.uv_s2 = r_reg.uv_s1;
		on_now = r_reg.run_s2 & operation_on;
		turn_on = on_now & ~r_reg.on_prev;
		r_next.on_prev = on_now;
		clr = clear_faults_cmd | restore_user_all_cmd | vendor_soft_reset_cmd | turn_on;
		active = (r_reg.state == ST_RUN) || (r_reg.state == ST_DELAY);
		arm_ok = active & ton_delay_done & ton_rise_done & ~seq_ramping & ton_limit_reached;
		r_next.armed = arm_ok & (r_reg.armed | ~r_reg.uv_s2);
		uv_evt = r_reg.armed & r_reg.uv_s2;
		ton_evt = ton_max_fault & active & (r_reg.ton_resp != TON_OFF);
		cur = r_reg.src_ton ? r_reg.ton_resp : r_reg.uv_resp;
		present = r_reg.src_ton ? ton_max_fault : r_reg.uv_s2;

		// Command writes and reads
		if (cmd_wr) begin
			case (cmd_code)
				CMD_UV_RESP: begin
					if (resp_of(cmd_wdata) == RESP_BAD) begin
						cml_set = 1'b1;
					end else begin
						r_next.uv_resp = cmd_wdata;
					end
				end
				CMD_TON_RESP: r_next.ton_resp = cmd_wdata;
				CMD_DIE_OT: cml_set = 1'b1;
				default: ;
			endcase
		end
		if (cmd_rd) begin
			case (cmd_code)
				CMD_UV_RESP: r_next.rdata = r_reg.uv_resp;
				CMD_TON_RESP: r_next.rdata = r_reg.ton_resp;
				CMD_DIE_OT: r_next.rdata = DIE_OT_VAL;
				default: r_next.rdata = RD_NONE;
			endcase
		end

		// Latched status, set wins over clear
		if (clr) begin
			r_next.st_noa = 1'b0;
			r_next.st_vout = 1'b0;
			r_next.st_uv = 1'b0;
			r_next.st_ton = 1'b0;
			r_next.cml = 1'b0;
		end
		if (uv_evt) begin
			r_next.st_noa = 1'b1;
			r_next.st_vout = 1'b1;
			r_next.st_uv = 1'b1;
		end
		if (ton_evt) begin
			r_next.st_noa = 1'b1;
			r_next.st_vout = 1'b1;
			r_next.st_ton = 1'b1;
		end
		if (cml_set) begin
			r_next.cml = 1'b1;
		end
		r_next.alert = (r_reg.st_uv & ~uv_alert_mask) | (r_reg.st_ton & ~ton_alert_mask)
			| (r_reg.cml & ~cml_alert_mask);

		// Response sequencing
		case (r_reg.state)
			ST_OFF: begin
				if (turn_on) begin
					r_next.state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (uv_evt || ton_evt) begin
					r_next.src_ton = ~uv_evt;
					cur = uv_evt ? r_reg.uv_resp : r_reg.ton_resp;
					case (resp_of(cur))
						RESP_DELAY: begin
							tif.load = 1'b1;
							tif.value = delay_of(cur);
							r_next.state = ST_DELAY;
						end
						RESP_SHUT: begin
							if (retry_of(cur) == RETRY_FOREVER) begin
								tif.load = 1'b1;
								tif.value = retry_interval_setting;
								r_next.state = ST_RETRY;
							end else begin
								r_next.state = ST_SHUT;
							end
						end
						default: ;
					endcase
				end
			end
			ST_DELAY: begin
				if (!present) begin
					r_next.state = ST_RUN;
				end else if (!tif.busy) begin
					if (retry_of(cur) == RETRY_FOREVER) begin
						tif.load = 1'b1;
						tif.value = retry_interval_setting;
						r_next.state = ST_RETRY;
					end else begin
						r_next.state = ST_SHUT;
					end
				end
			end
			ST_SHUT: begin
				if (clr && on_now) begin
					r_next.state = ST_RUN;
				end
			end
			ST_RETRY: begin
				if (!tif.busy) begin
					r_next.state = ST_RUN;
				end
			end
			default: r_next.state = ST_OFF;
		endcase
		if (!on_now) begin
			r_next.state = ST_OFF;
		end
		r_next.out_en = (r_next.state == ST_RUN) || (r_next.state == ST_DELAY);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r_reg <= RST_VAL;
		end else begin
			r_reg <= r_next;
		end
	end

	assign cmd_rdata = r_reg.rdata;
	assign output_enable = r_reg.out_en;
	assign status_none_of_above = r_reg.st_noa;
	assign status_word_vout = r_reg.st_vout;
	assign status_vout_uv = r_reg.st_uv;
	assign status_vout_ton_max = r_reg.st_ton;
	assign cml_fault = r_reg.cml;
	assign alert_o = 1'b0;
	assign alert_oe = r_reg.alert;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence uv_hit(logic [1:0] code);
		r_reg.state == ST_RUN && uv_evt && on_now && resp_of(r_reg.uv_resp) == code;
	endsequence
	sequence uv_delay_over;
		r_reg.state == ST_DELAY && present && !tif.busy && on_now;
	endsequence

	ignore_code_a: assert property (uv_hit(RESP_IGNORE) |=> r_reg.state == ST_RUN && output_enable)
		else $error("ignore code disturbed regulation");
	delay_go_a: assert property (uv_hit(RESP_DELAY) |=> r_reg.state == ST_DELAY && output_enable)
		else $error("delay code did not keep running");
	delay_end_a: assert property (uv_delay_over |=> !output_enable)
		else $error("persistent fault not acted on after delay");
	shut_now_a: assert property (uv_hit(RESP_SHUT) |=> !output_enable)
		else $error("shutdown code left output on");
	bad_code_a: assert property ((cmd_wr && cmd_code == CMD_UV_RESP && resp_of(cmd_wdata) == RESP_BAD)
		|=> cml_fault && $stable(r_reg.uv_resp))
		else $error("unsupported code was accepted");
	no_retry_a: assert property ((r_reg.state == ST_SHUT && !clr) |=> !output_enable)
		else $error("no-retry shutdown restarted");
	retry_go_a: assert property ((r_reg.state == ST_RETRY && !tif.busy && on_now) |=> output_enable)
		else $error("continuous retry did not restart");
	retry_gap_a: assert property ((tif.load && r_next.state == ST_RETRY) |-> tif.value == retry_interval_setting)
		else $error("retry spacing not from interval setting");
	delay_val_a: assert property ((tif.load && r_next.state == ST_DELAY) |-> tif.value == delay_of(cur))
		else $error("delay not from bits 2:0");
	uv_flags_a: assert property (uv_evt |=> status_vout_uv && status_none_of_above && status_word_vout)
		else $error("undervoltage status not latched");
	uv_alert_a: assert property ((status_vout_uv && !uv_alert_mask) |=> alert_oe && !alert_o)
		else $error("unmasked fault without alert");
	latch_hold_a: assert property ((status_vout_uv && !clr) |=> status_vout_uv)
		else $error("fault bit cleared without cause");
	ton_flags_a: assert property (ton_evt |=> status_vout_ton_max && status_word_vout)
		else $error("timeout status not latched");
	ton_zero_a: assert property ((r_reg.ton_resp == TON_OFF && !status_vout_ton_max) |=> !status_vout_ton_max)
		else $error("disabled timeout response acted");
	die_ot_a: assert property ((cmd_rd && cmd_code == CMD_DIE_OT) |=> cmd_rdata == DIE_OT_VAL)
		else $error("die overtemp response misread");
	uv_mask_a: assert property ((seq_ramping || !ton_rise_done) |=> !r_reg.armed)
		else $error("undervoltage armed while masked");
endmodule // uvtm_fault_resp

// ==== pkg/uvtm_pkg.sv ====
package uvtm_pkg;
	// Clock and 10 us step
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned STEP_US = 10;
	localparam int unsigned TICK_CYC = STEP_US * (CLK_HZ / 1_000_000);
	localparam int DIV_W = 8;
	localparam int CNT_W = 16;
	localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_CYC - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	// Response byte fields
	localparam int RESP_HI = 7;
	localparam int RESP_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DLY_HI = 2;
	localparam int DLY_LO = 0;
	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_DELAY = 2'h1;
	localparam logic [1:0] RESP_SHUT = 2'h2;
	localparam logic [1:0] RESP_BAD = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// Command codes and values
	localparam logic [7:0] CMD_DIE_OT = 8'hD6;
	localparam logic [7:0] DIE_OT_VAL = 8'hC0;
	localparam logic [7:0] CMD_UV_RESP = 8'h45;
	localparam logic [7:0] CMD_TON_RESP = 8'h63;
	localparam logic [7:0] UV_RESP_RST = 8'h80;
	localparam logic [7:0] TON_RESP_RST = 8'hB8;
	localparam logic [7:0] TON_OFF = 8'h00;
	localparam logic [7:0] RD_NONE = 8'h00;

	typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_DELAY, ST_SHUT, ST_RETRY} uvtm_state_t;

	function automatic logic [1:0] resp_of(input logic [7:0] b);
		return b[RESP_HI:RESP_LO];
	endfunction

	function automatic logic [2:0] retry_of(input logic [7:0] b);
		return b[RETRY_HI:RETRY_LO];
	endfunction

	function automatic logic [CNT_W-1:0] delay_of(input logic [7:0] b);
		return {13'h0000, b[DLY_HI:DLY_LO]};
	endfunction
endpackage

// ==== pkg/uvtm_tmr_if.sv ====
`timescale 1ns/100ps
interface uvtm_tmr_if;
	import uvtm_pkg::*;
	logic load;
	logic [CNT_W-1:0] value;
	logic busy;
	modport ctrl (output load, output value, input busy);
	modport tmr (input load, input value, output busy);
endinterface

// ==== hw/uvtm_timer.sv ====
`timescale 1ns/100ps
module uvtm_timer
	import uvtm_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Control side
	uvtm_tmr_if.tmr t
);
	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [CNT_W-1:0] cnt;
	} uvtm_tstate_t;

	uvtm_tstate_t r_reg, r_next;

	always_comb begin
		r_next = r_reg;
		if (t.load) begin
			r_next.cnt = t.value;
			r_next.div = DIV_ZERO;
		end else if (r_reg.cnt != CNT_ZERO) begin
			if (r_reg.div == TICK_LAST) begin
				r_next.div = DIV_ZERO;
				r_next.cnt = r_reg.cnt - CNT_ONE;
			end else begin
				r_next.div = r_reg.div + 8'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign t.busy = r_reg.cnt != CNT_ZERO;

	step_tick_a: assert property (@(posedge clock) disable iff (!nrst)
		(r_reg.cnt != CNT_ZERO && r_reg.div == TICK_LAST && !t.load) |=> r_reg.cnt == $past(r_reg.cnt) - CNT_ONE)
		else $error("delay counter missed a 10 us step");
	step_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		(r_reg.div != TICK_LAST && !t.load) |=> $stable(r_reg.cnt))
		else $error("delay counter moved between steps");
	load_zero_a: assert property (@(posedge clock) disable iff (!nrst)
		(t.load && t.value == CNT_ZERO) |=> !t.busy)
		else $error("zero delay left the timer busy");
endmodule // uvtm_timer

// ==== testbench/uvtm_host.sv ====
`timescale 1ns/100ps
module uvtm_host (
	// Clock
	clock,
	// Command port
	cmd_wr,
	cmd_rd,
	cmd_code,
	cmd_wdata
);
	input wire logic clock;
	output logic cmd_wr;
	output logic cmd_rd;
	output logic [7:0] cmd_code;
	output logic [7:0] cmd_wdata;
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 8'h00;
	end
	// One byte write
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(posedge clock) #1;
		cmd_wr = 1'b1;
		cmd_code = c;
		cmd_wdata = d;
		@(posedge clock) #1;
		cmd_wr = 1'b0;
		cmd_code = ~c;
		cmd_wdata = ~d;
	endtask
	// One byte read
	task automatic rd(input logic [7:0] c);
		@(posedge clock) #1;
		cmd_rd = 1'b1;
		cmd_code = c;
		@(posedge clock) #1;
		cmd_rd = 1'b0;
		cmd_code = ~c;
	endtask
endmodule // uvtm_host

// ==== testbench/uvtm_fault_resp_tb.sv ====
`timescale 1ns/100ps
module uvtm_fault_resp_tb;
	import uvtm_pkg::*;
	logic clock = 1'b0;
	logic nrst, clr, rua, vsr, run_pin, op_on, ramp, uv, ton, uv_mask, seq_ok;
	logic cmd_wr, cmd_rd, oe, noa, wv, suv, ston, cml, alert_o, alert_oe;
	logic [7:0] cmd_code, cmd_wdata, cmd_rdata, d;
	logic [CNT_W-1:0] rint;
	logic [7:0] exp_q[$];
	logic rd_q = 1'b0;
	logic [31:0] lfsr = 32'h0E86;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	wire logic [7:0] st = {alert_oe, cml, noa, wv, suv, ston, alert_o, oe};
	initial begin
		forever #20 clock = ~clock;
	end
	uvtm_host i_uvtm_host (.clock(clock), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata));
	uvtm_fault_resp i_uvtm_fault_resp (.clock(clock), .nrst(nrst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .clear_faults_cmd(clr),
		.restore_user_all_cmd(rua), .vendor_soft_reset_cmd(vsr), .run_pin(run_pin), .operation_on(op_on),
		.ton_delay_done(seq_ok), .ton_rise_done(seq_ok), .seq_ramping(ramp), .ton_limit_reached(seq_ok),
		.uv_below(uv), .ton_max_fault(ton), .retry_interval_setting(rint), .uv_alert_mask(uv_mask),
		.ton_alert_mask(1'b0), .cml_alert_mask(1'b1), .output_enable(oe), .status_none_of_above(noa),
		.status_word_vout(wv), .status_vout_uv(suv), .status_vout_ton_max(ston), .cml_fault(cml),
		.alert_o(alert_o), .alert_oe(alert_oe));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("tests_run %0d fail_count %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic rd_exp(input logic [7:0] c, input logic [7:0] e);
		exp_q.push_back(e);
		i_uvtm_host.rd(c);
	endtask
	// Read result monitor
	always @(posedge clock) rd_q <= cmd_rd;
	always @(negedge clock) begin
		if (rd_q) begin
			check(cmd_rdata, exp_q.pop_front());
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 12000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		{nrst, clr, rua, vsr, run_pin, op_on, ramp, uv, ton, uv_mask} = 10'h000;
		rint = 16'h0003;
		seq_ok = 1'b1;
		repeat (12) @(posedge clock);
		#1;
		nrst = 1'b1;
		// Reset values, read-only byte, unknown code
		rd_exp(CMD_UV_RESP, UV_RESP_RST);
		rd_exp(CMD_TON_RESP, TON_RESP_RST);
		rd_exp(CMD_DIE_OT, 8'hC0);
		rd_exp(8'h10, 8'h00);
		// Random legal response bytes
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			d = lfsr[7:0] & ((lfsr[7:6] == 2'h3) ? 8'h7F : 8'hFF);
			i_uvtm_host.wr(CMD_UV_RESP, d);
			rd_exp(CMD_UV_RESP, d);
		end
		// Refused writes
		i_uvtm_host.wr(CMD_UV_RESP, 8'hC5);
		i_uvtm_host.wr(CMD_DIE_OT, 8'h12);
		rd_exp(CMD_UV_RESP, d);
		rd_exp(CMD_DIE_OT, 8'hC0);
		tick(2);
		check(st, 8'h40);
		pulse(clr);
		tick(2);
		check(st, 8'h00);
		// Channel up
		{run_pin, op_on} = 2'h3;
		tick(5);
		check(st, 8'h01);
		// Ignore code
		i_uvtm_host.wr(CMD_UV_RESP, 8'h00);
		uv = 1'b1;
		tick(8);
		check(st, 8'hB9);
		uv = 1'b0;
		tick(20);
		check(st, 8'hB9);
		pulse(rua);
		tick(3);
		check(st, 8'h01);
		// Run-on delay of two steps, alert masked
		uv_mask = 1'b1;
		i_uvtm_host.wr(CMD_UV_RESP, 8'h42);
		uv = 1'b1;
		tick(400);
		check(st, 8'h39);
		tick(200);
		check(st, 8'h38);
		uv = 1'b0;
		tick(300);
		check(st, 8'h38);
		pulse(vsr);
		tick(6);
		check(st, 8'h01);
		uv_mask = 1'b0;
		// Immediate shutdown, cleared by off then on
		i_uvtm_host.wr(CMD_UV_RESP, 8'h80);
		uv = 1'b1;
		tick(6);
		uv = 1'b0;
		check(st, 8'hB8);
		op_on = 1'b0;
		tick(4);
		check(st, 8'hB8);
		op_on = 1'b1;
		tick(6);
		check(st, 8'h01);
		// Masked while ramping
		ramp = 1'b1;
		uv = 1'b1;
		tick(8);
		check(st, 8'h01);
		uv = 1'b0;
		ramp = 1'b0;
		tick(4);
		// Masked while sequencing unfinished
		seq_ok = 1'b0;
		uv = 1'b1;
		tick(8);
		check(st, 8'h01);
		uv = 1'b0;
		seq_ok = 1'b1;
		tick(4);
		// Retry forever with interval of three steps
		i_uvtm_host.wr(CMD_UV_RESP, 8'hB8);
		uv = 1'b1;
		tick(6);
		uv = 1'b0;
		check(st, 8'hB8);
		tick(500);
		check(st, 8'hB8);
		tick(400);
		check(st, 8'hB9);
		pulse(clr);
		tick(3);
		// Timeout fault with default response
		ton = 1'b1;
		tick(8);
		check(st, 8'hB4);
		ton = 1'b0;
		// Power cycle clears status and restores bytes
		nrst = 1'b0;
		tick(2);
		check(st, 8'h00);
		nrst = 1'b1;
		rd_exp(CMD_UV_RESP, UV_RESP_RST);
		// Timeout response disabled
		i_uvtm_host.wr(CMD_TON_RESP, TON_OFF);
		tick(5);
		ton = 1'b1;
		tick(8);
		check(st, 8'h01);
		ton = 1'b0;
		tick(4);
		complete_run();
	end
endmodule // uvtm_fault_resp_tb
